/* inc/scc_map.vh */
// constants for the system control and cache operation decoder
// assumes a 32-bit big-endian instruction word, bit 0 the most significant
// What this block does
// - an instruction cache invalidate translates and protection-checks its address before touching the cache.
// - an instruction cache invalidate that hits marks the block invalid.
// - an instruction cache invalidate leaves data cache contents and state untouched.
// - an instruction cache invalidate that passes translation in a segment without the direct-store bit is broadcast on the system bus, hit or miss.
// - external control word in and out raise an alignment exception on an address not a multiple of four.
// - system call runs at user level and always takes an exception.
// - return from interrupt is accepted only at supervisor level.
// - machine state write loads the state register from a general register, the read copies it back.
// - special register moves reach supervisor registers by number, to or from a general register.
// - the special register number takes its high half from bits 16 to 20 and its low half from bits 11 to 15.
// - numbers 952, 953, 954, 955, 959, 1010 and 1023 select the implementation registers.
// - a data cache invalidate translates and checks protection with store semantics.
// - a data cache invalidate broadcasts a kill for the block on the system bus.
// - a data cache invalidate that hits marks the block invalid even if modified, with no write back.
// - a cache control instruction whose segment has the direct-store type bit set completes as a no-op.
`ifndef SCC_MAP_VH
`define SCC_MAP_VH
// ----------------------------------------
// primary and extended opcodes
// ----------------------------------------
`define SCC_OP_SYSCALL 6'h11
`define SCC_OP_RFI_GRP 6'h13
`define SCC_OP_EXT 6'h1F
`define SCC_XO_RFI 10'h032
`define SCC_XO_MTMSR 10'h092
`define SCC_XO_MFMSR 10'h053
`define SCC_XO_MTSPR 10'h1D3
`define SCC_XO_MFSPR 10'h153
`define SCC_XO_ICBI 10'h3D6
`define SCC_XO_DCBI 10'h1D6
`define SCC_XO_ECIWX 10'h136
`define SCC_XO_ECOWX 10'h1B6
// ----------------------------------------
// special register numbers
// ----------------------------------------
`define SCC_SPR_PERF_CTRL 10'h3B8
`define SCC_SPR_PERF_CNT1 10'h3B9
`define SCC_SPR_PERF_CNT2 10'h3BA
`define SCC_SPR_SAMP_IADDR 10'h3BB
`define SCC_SPR_SAMP_DADDR 10'h3BF
`define SCC_SPR_IBRK_ADDR 10'h3F2
`define SCC_SPR_PROC_ID 10'h3FF
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SCC_MSR_PR_BIT 14
`define SCC_MSR_RESET 32'h00000000
`define SCC_SPR_RESET 32'h00000000
// ----------------------------------------
// exception causes
// ----------------------------------------
`define SCC_EXC_NONE 3'h0
`define SCC_EXC_SYSCALL 3'h1
`define SCC_EXC_PRIV 3'h2
`define SCC_EXC_ILLEGAL 3'h3
`define SCC_EXC_ALIGN 3'h4
`define SCC_EXC_PROT 3'h5
`define SCC_EXC_RFI 3'h6
// ----------------------------------------
// bus operations
// ----------------------------------------
`define SCC_BUS_NONE 2'h0
`define SCC_BUS_ICBI 2'h1
`define SCC_BUS_KILL 2'h2
`endif

/* rtl/scc_spr_file.v */
// implementation special register file, one write port, one read port
// assumes the caller decodes legal numbers and privilege
`timescale 1ns/100ps
`default_nettype none
`include "scc_map.vh"
module scc_spr_file #(
  parameter WIDTH = 32
) (
  input wire clk,
  input wire rst,
  input wire wrEn,
  input wire [9:0] wrNum,
  input wire [WIDTH-1:0] wrData,
  input wire [9:0] rdNum,
  output reg [WIDTH-1:0] rdData
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [WIDTH-1:0] perfMonitorControl;
  reg [WIDTH-1:0] perfCounterOne;
  reg [WIDTH-1:0] perfCounterTwo;
  reg [WIDTH-1:0] sampledInstrAddrReg;
  reg [WIDTH-1:0] sampledDataAddrReg;
  reg [WIDTH-1:0] instrBreakpointAddr;
  reg [WIDTH-1:0] processorIdReg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      perfMonitorControl <= `SCC_SPR_RESET;
      perfCounterOne <= `SCC_SPR_RESET;
      perfCounterTwo <= `SCC_SPR_RESET;
      sampledInstrAddrReg <= `SCC_SPR_RESET;
      sampledDataAddrReg <= `SCC_SPR_RESET;
      instrBreakpointAddr <= `SCC_SPR_RESET;
      processorIdReg <= `SCC_SPR_RESET;
    end else if (wrEn) begin
      case (wrNum)
        `SCC_SPR_PERF_CTRL: perfMonitorControl <= wrData;
        `SCC_SPR_PERF_CNT1: perfCounterOne <= wrData;
        `SCC_SPR_PERF_CNT2: perfCounterTwo <= wrData;
        `SCC_SPR_SAMP_IADDR: sampledInstrAddrReg <= wrData;
        `SCC_SPR_SAMP_DADDR: sampledDataAddrReg <= wrData;
        `SCC_SPR_IBRK_ADDR: instrBreakpointAddr <= wrData;
        `SCC_SPR_PROC_ID: processorIdReg <= wrData;
        default: ;
      endcase
    end
  end
  always @* begin
    case (rdNum)
      `SCC_SPR_PERF_CTRL: rdData = perfMonitorControl;
      `SCC_SPR_PERF_CNT1: rdData = perfCounterOne;
      `SCC_SPR_PERF_CNT2: rdData = perfCounterTwo;
      `SCC_SPR_SAMP_IADDR: rdData = sampledInstrAddrReg;
      `SCC_SPR_SAMP_DADDR: rdData = sampledDataAddrReg;
      `SCC_SPR_IBRK_ADDR: rdData = instrBreakpointAddr;
      `SCC_SPR_PROC_ID: rdData = processorIdReg;
      default: rdData = {WIDTH{1'b0}};
    endcase
  end
endmodule // scc_spr_file
`default_nettype wire

/* rtl/scc_sys_ctrl_decode.v */
// decode and execution control of system, state-move and cache-invalidate instructions
// assumes a core pipeline presenting one instruction with operands and a translation unit answering in time
`timescale 1ns/100ps
`default_nettype none
`include "scc_map.vh"
module scc_sys_ctrl_decode (
  input wire clk,
  input wire rst,
  // issue
  input wire issueValid,
  input wire [31:0] instr,
  input wire [31:0] gprA,
  input wire [31:0] gprB,
  input wire [31:0] gprS,
  // translation answer
  input wire xlateDone,
  input wire xlateProtFault,
  input wire segDirectStore,
  input wire icacheHit,
  input wire dcacheHit,
  // issue and translation requests
  output reg busy,
  output reg xlateReq,
  output reg [31:0] xlateEa,
  output reg xlateIsStore,
  // cache actions
  output reg icacheInval,
  output reg dcacheInval,
  output reg [31:0] cacheAddr,
  // system bus
  output reg [1:0] busOp,
  output reg busOpValid,
  output reg [31:0] busAddr,
  input wire busOpAck,
  // completion
  output reg done,
  output reg excValid,
  output reg [2:0] excCause,
  output reg gprWrEn,
  output reg [4:0] gprWrIdx,
  output reg [31:0] gprWrData,
  output reg [31:0] machineStateReg
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function [9:0] sprNumber;
    input [31:0] ins;
    begin
      sprNumber = {ins[15:11], ins[20:16]};
    end
  endfunction
  function sprDefined;
    input [9:0] num;
    begin
      case (num)
        `SCC_SPR_PERF_CTRL, `SCC_SPR_PERF_CNT1, `SCC_SPR_PERF_CNT2, `SCC_SPR_SAMP_IADDR,
        `SCC_SPR_SAMP_DADDR, `SCC_SPR_IBRK_ADDR, `SCC_SPR_PROC_ID: sprDefined = 1'b1;
        default: sprDefined = 1'b0;
      endcase
    end
  endfunction
  // ----------------------------------------
  // state machine
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_XLATE = 2'h1;
  localparam ST_BUS = 2'h2;
  reg [1:0] state;
  reg isIcbi;
  reg sprWrEn;
  reg [9:0] sprWrNum;
  reg [31:0] sprWrData;
  wire [31:0] sprRdData;
  // big-endian bit n is vector bit 31-n
  wire [5:0] opcode = instr[31:26];
  wire [9:0] xo = instr[10:1];
  wire [4:0] fieldD = instr[25:21];
  wire [4:0] fieldA = instr[20:16];
  wire userMode = machineStateReg[`SCC_MSR_PR_BIT];
  wire [31:0] effAddr = ((fieldA == 5'h00) ? 32'h00000000 : gprA) + gprB;
  wire isExt = (opcode == `SCC_OP_EXT);
  wire isSyscall = (opcode == `SCC_OP_SYSCALL);
  wire isRfi = (opcode == `SCC_OP_RFI_GRP) && (xo == `SCC_XO_RFI);
  wire isMtmsr = isExt && (xo == `SCC_XO_MTMSR);
  wire isMfmsr = isExt && (xo == `SCC_XO_MFMSR);
  wire isMtspr = isExt && (xo == `SCC_XO_MTSPR);
  wire isMfspr = isExt && (xo == `SCC_XO_MFSPR);
  wire isIcbiOp = isExt && (xo == `SCC_XO_ICBI);
  wire isDcbi = isExt && (xo == `SCC_XO_DCBI);
  wire isExtCtl = isExt && ((xo == `SCC_XO_ECIWX) || (xo == `SCC_XO_ECOWX));
  wire [9:0] sprNum = sprNumber(instr);
  scc_spr_file #(
    .WIDTH(32)
  ) u_spr (
    .clk(clk),
    .rst(rst),
    .wrEn(sprWrEn),
    .wrNum(sprWrNum),
    .wrData(sprWrData),
    .rdNum(sprNum),
    .rdData(sprRdData)
  );
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      xlateReq <= 1'b0;
      xlateEa <= 32'h00000000;
      xlateIsStore <= 1'b0;
      icacheInval <= 1'b0;
      dcacheInval <= 1'b0;
      cacheAddr <= 32'h00000000;
      busOp <= `SCC_BUS_NONE;
      busOpValid <= 1'b0;
      busAddr <= 32'h00000000;
      done <= 1'b0;
      excValid <= 1'b0;
      excCause <= `SCC_EXC_NONE;
      gprWrEn <= 1'b0;
      gprWrIdx <= 5'h00;
      gprWrData <= 32'h00000000;
      machineStateReg <= `SCC_MSR_RESET;
      isIcbi <= 1'b0;
      sprWrEn <= 1'b0;
      sprWrNum <= 10'h000;
      sprWrData <= 32'h00000000;
    end else begin
      done <= 1'b0;
      excValid <= 1'b0;
      excCause <= `SCC_EXC_NONE;
      gprWrEn <= 1'b0;
      icacheInval <= 1'b0;
      dcacheInval <= 1'b0;
      sprWrEn <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (issueValid) begin
            if (isSyscall) begin
              // allowed at any level, always traps
              done <= 1'b1;
              excValid <= 1'b1;
              excCause <= `SCC_EXC_SYSCALL;
            end else if (userMode && (isRfi || isMtmsr || isMfmsr || isDcbi ||
                         ((isMtspr || isMfspr) && sprNum[4]))) begin
              // spr number bit 4, the top bit of the low half, set marks a supervisor register
              done <= 1'b1;
              excValid <= 1'b1;
              excCause <= `SCC_EXC_PRIV;
            end else if (isRfi) begin
              done <= 1'b1;
              excValid <= 1'b1;
              excCause <= `SCC_EXC_RFI;
            end else if (isMtmsr) begin
              machineStateReg <= gprS;
              done <= 1'b1;
            end else if (isMfmsr) begin
              gprWrEn <= 1'b1;
              gprWrIdx <= fieldD;
              gprWrData <= machineStateReg;
              done <= 1'b1;
            end else if ((isMtspr || isMfspr) && !sprDefined(sprNum)) begin
              done <= 1'b1;
              excValid <= 1'b1;
              excCause <= `SCC_EXC_ILLEGAL;
            end else if (isMtspr) begin
              sprWrEn <= 1'b1;
              sprWrNum <= sprNum;
              sprWrData <= gprS;
              done <= 1'b1;
            end else if (isMfspr) begin
              gprWrEn <= 1'b1;
              gprWrIdx <= fieldD;
              gprWrData <= sprRdData;
              done <= 1'b1;
            end else if (isExtCtl && (effAddr[1:0] != 2'h0)) begin
              done <= 1'b1;
              excValid <= 1'b1;
              excCause <= `SCC_EXC_ALIGN;
            end else if (isExtCtl) begin
              // the device side of the transfer is outside this block
              done <= 1'b1;
            end else if (isIcbiOp || isDcbi) begin
              busy <= 1'b1;
              xlateReq <= 1'b1;
              xlateEa <= effAddr;
              xlateIsStore <= isDcbi;
              isIcbi <= isIcbiOp;
              state <= ST_XLATE;
            end else begin
              done <= 1'b1;
              excValid <= 1'b1;
              excCause <= `SCC_EXC_ILLEGAL;
            end
          end
        end
        ST_XLATE: begin
          xlateReq <= 1'b0;
          if (xlateDone) begin
            cacheAddr <= xlateEa;
            if (xlateProtFault) begin
              // no cache is touched before the check passes
              busy <= 1'b0;
              done <= 1'b1;
              excValid <= 1'b1;
              excCause <= `SCC_EXC_PROT;
              state <= ST_IDLE;
            end else if (segDirectStore) begin
              busy <= 1'b0;
              done <= 1'b1;
              state <= ST_IDLE;
            end else begin
              // only the own cache is invalidated, data cache left alone for icbi
              icacheInval <= isIcbi && icacheHit;
              dcacheInval <= !isIcbi && dcacheHit;
              busOp <= isIcbi ? `SCC_BUS_ICBI : `SCC_BUS_KILL;
              busOpValid <= 1'b1;
              busAddr <= xlateEa;
              state <= ST_BUS;
            end
          end
        end
        ST_BUS: begin
          if (busOpAck) begin
            busOpValid <= 1'b0;
            busOp <= `SCC_BUS_NONE;
            busy <= 1'b0;
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule // scc_sys_ctrl_decode
`default_nettype wire

/* sim/scc_monitor.sv */
// concurrent checks on the system control decoder ports
// assumes binding to scc_sys_ctrl_decode, single clock domain
`timescale 1ns/100ps
`default_nettype none
`include "scc_map.vh"
module scc_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic issueValid,
  input wire logic [31:0] instr,
  input wire logic [31:0] gprA,
  input wire logic [31:0] gprB,
  input wire logic busy,
  input wire logic xlateReq,
  input wire logic xlateIsStore,
  input wire logic icacheInval,
  input wire logic dcacheInval,
  input wire logic [1:0] busOp,
  input wire logic busOpValid,
  input wire logic [31:0] busAddr,
  input wire logic busOpAck,
  input wire logic done,
  input wire logic excValid,
  input wire logic [2:0] excCause,
  input wire logic [31:0] machineStateReg
);
  // ----------------------------------------
  // decode helpers and properties
  // ----------------------------------------
  wire take = issueValid && !busy;
  wire [9:0] xo = instr[31:26] == `SCC_OP_EXT ? instr[10:1] : 10'h000;
  wire user = machineStateReg[`SCC_MSR_PR_BIT];
  // only the low bits matter for word alignment
  wire [1:0] ea = (instr[20:16] == 5'h00 ? 2'h0 : gprA[1:0]) + gprB[1:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_sys_trap: assert property (take && instr[31:26] == `SCC_OP_SYSCALL
    |=> excValid && excCause == `SCC_EXC_SYSCALL) else $error("system call gave no trap");
  a_align_trap: assert property (take && (xo == `SCC_XO_ECIWX || xo == `SCC_XO_ECOWX) && ea != 2'h0
    |=> excValid && excCause == `SCC_EXC_ALIGN) else $error("misaligned external word not trapped");
  a_rfi_level: assert property (take && instr[31:26] == `SCC_OP_RFI_GRP && instr[10:1] == `SCC_XO_RFI
    |=> excValid && excCause == ($past(user) ? `SCC_EXC_PRIV : `SCC_EXC_RFI)) else $error("rfi level wrong");
  a_priv_trap: assert property (take && user && xo == `SCC_XO_DCBI
    |=> excValid && excCause == `SCC_EXC_PRIV && !xlateReq) else $error("user dcbi not refused");
  a_store_req: assert property (take && !user && xo == `SCC_XO_DCBI
    |=> xlateReq && xlateIsStore) else $error("dcbi translation not store");
  a_icbi_req: assert property (take && xo == `SCC_XO_ICBI
    |=> xlateReq && !xlateIsStore) else $error("icbi not translated");
  a_iinval_bus: assert property (icacheInval
    |-> busOpValid && busOp == `SCC_BUS_ICBI && !dcacheInval) else $error("icbi inval wrong");
  a_kill_bus: assert property (dcacheInval
    |-> busOpValid && busOp == `SCC_BUS_KILL) else $error("dcbi inval without kill");
  a_bus_hold: assert property (busOpValid && !busOpAck
    |=> busOpValid && $stable(busOp) && $stable(busAddr)) else $error("bus op dropped early");
  a_ack_done: assert property (busOpValid && busOpAck
    |=> done && !busy && !busOpValid) else $error("no completion after ack");
endmodule // scc_monitor
bind scc_sys_ctrl_decode scc_monitor mon (.clk, .rst, .issueValid, .instr, .gprA, .gprB, .busy, .xlateReq,
  .xlateIsStore, .icacheInval, .dcacheInval, .busOp, .busOpValid, .busAddr, .busOpAck, .done, .excValid,
  .excCause, .machineStateReg);
`default_nettype wire

/* sim/scc_bus_model.sv */
// system bus responder that acknowledges broadcast operations
// assumes one requester holding busOpValid until acknowledged
`timescale 1ns/100ps
`default_nettype none
module scc_bus_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic busOpValid,
  input wire logic [3:0] ackDelay,
  output logic busOpAck
);
  // ----------------------------------------
  // delayed one-cycle acknowledge
  // ----------------------------------------
  logic [3:0] waitCnt;
  wire pend = busOpValid && !busOpAck;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busOpAck <= 1'b0;
      waitCnt <= 4'h0;
    end else begin
      busOpAck <= pend && waitCnt == ackDelay;
      waitCnt <= (pend && waitCnt != ackDelay) ? waitCnt + 4'h1 : 4'h0;
    end
  end
endmodule // scc_bus_model
`default_nettype wire

/* sim/scc_tb.sv */
// self-checking bench for the system control decoder
// assumes decoder, bus model and map header compiled first
`timescale 1ns/100ps
`default_nettype none
`include "scc_map.vh"
module tb;
  logic clk = 1'b0, rst = 1'b1, issueValid = 1'b0;
  logic xlateDone = 1'b0, xlateProtFault = 1'b0, segDirectStore = 1'b0, icacheHit = 1'b0, dcacheHit = 1'b0;
  logic [31:0] instr = 32'h0, gprA = 32'h0, gprB = 32'h0, gprS = 32'h0;
  logic [3:0] ackDelay = 4'h0;
  logic [9:0] nums [7] = '{10'h3B8, 10'h3B9, 10'h3BA, 10'h3BB, 10'h3BF, 10'h3F2, 10'h3FF};
  localparam logic [31:0] sysWord = {`SCC_OP_SYSCALL, 24'h0, 2'h2};
  localparam logic [31:0] rfiWord = {`SCC_OP_RFI_GRP, 15'h0, `SCC_XO_RFI, 1'b0};
  wire busy, xlateReq, xlateIsStore, icacheInval, dcacheInval, busOpValid, busOpAck, done, excValid, gprWrEn;
  wire [31:0] xlateEa, cacheAddr, busAddr, gprWrData, machineStateReg;
  wire [1:0] busOp;
  wire [2:0] excCause;
  wire [4:0] gprWrIdx;
  int errors = 0, total_checks = 0, cycles = 0;
  always #20 clk = ~clk;
  scc_sys_ctrl_decode dut (.clk, .rst, .issueValid, .instr, .gprA, .gprB, .gprS, .xlateDone, .xlateProtFault,
    .segDirectStore, .icacheHit, .dcacheHit, .busy, .xlateReq, .xlateEa, .xlateIsStore, .icacheInval, .dcacheInval,
    .cacheAddr, .busOp, .busOpValid, .busAddr, .busOpAck, .done, .excValid, .excCause, .gprWrEn, .gprWrIdx,
    .gprWrData, .machineStateReg);
  scc_bus_model bus (.clk, .rst, .busOpValid, .ackDelay, .busOpAck);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // a hang costs at most this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end
  function automatic logic [31:0] xf(input logic [9:0] xo, input logic [4:0] d, a, b);
    return {`SCC_OP_EXT, d, a, b, xo, 1'b0};
  endfunction
  task automatic issue(input logic [31:0] ins, a, b, s);
    @(posedge clk);
    instr <= ins;
    gprA <= a;
    gprB <= b;
    gprS <= s;
    issueValid <= 1'b1;
    @(posedge clk);
    issueValid <= 1'b0;
    #1;
  endtask
  task automatic exc(input logic [31:0] ins, a, b, input logic [2:0] cause);
    issue(ins, a, b, 32'h0);
    chk("done", done, 1'b1);
    chk("excValid", excValid, cause != 3'h0);
    if (cause != 3'h0) chk("excCause", excCause, cause);
  endtask
  task automatic cache(input logic [9:0] xo, input logic hit, fault, ds, input logic [1:0] expOp,
      input logic [2:0] cause);
    logic sawI, sawD;
    logic [1:0] op;
    logic [31:0] ba;
    int n;
    sawI = 1'b0;
    sawD = 1'b0;
    op = 2'h0;
    ba = 32'h0;
    n = 0;
    issue(xf(xo, 5'h00, 5'h02, 5'h03), 32'h1000, 32'h40, 32'h0);
    chk("xlateReq", xlateReq, 1'b1);
    chk("xlateEa", xlateEa, 32'h1040);
    chk("xlateIsStore", xlateIsStore, xo == `SCC_XO_DCBI);
    chk("busy", busy, 1'b1);
    @(posedge clk);
    xlateDone <= 1'b1;
    xlateProtFault <= fault;
    segDirectStore <= ds;
    icacheHit <= hit;
    dcacheHit <= hit;
    @(posedge clk);
    xlateDone <= 1'b0;
    do begin
      #1;
      sawI |= icacheInval;
      sawD |= dcacheInval;
      if (busOpValid) begin
        op = busOp;
        ba = busAddr;
      end
      if (!done) @(posedge clk);
      n++;
    end while (!done && n < 30);
    chk("done", done, 1'b1);
    chk("icacheInval", sawI, xo == `SCC_XO_ICBI && hit && !fault && !ds);
    chk("dcacheInval", sawD, xo == `SCC_XO_DCBI && hit && !fault && !ds);
    chk("busOp", op, expOp);
    chk("busAddr", ba, expOp != `SCC_BUS_NONE ? 32'h1040 : 32'h0);
    chk("cacheAddr", cacheAddr, 32'h1040);
    chk("busyEnd", busy, 1'b0);
    chk("excCause", excValid ? excCause : 3'h0, cause);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_msr;
    chk("msrReset", machineStateReg, 32'h0);
    issue(xf(`SCC_XO_MTMSR, 5'h03, 5'h00, 5'h00), 32'h0, 32'h0, 32'h5A5A0A5A);
    issue(xf(`SCC_XO_MFMSR, 5'h07, 5'h00, 5'h00), 32'h0, 32'h0, 32'h0);
    chk("gprWrEn", gprWrEn, 1'b1);
    chk("gprWrIdx", gprWrIdx, 5'h07);
    chk("gprWrData", gprWrData, 32'h5A5A0A5A);
    $display("test msr done");
  endtask
  task automatic t_spr;
    for (int i = 0; i < 7; i++) issue(xf(`SCC_XO_MTSPR, 5'h01, nums[i][4:0], nums[i][9:5]), 0, 0, 32'hC0DE0000 + i);
    for (int i = 0; i < 7; i++) begin
      issue(xf(`SCC_XO_MFSPR, 5'h04, nums[i][4:0], nums[i][9:5]), 0, 0, 0);
      chk("sprRead", gprWrData, 32'hC0DE0000 + i);
    end
    exc(xf(`SCC_XO_MTSPR, 5'h01, 5'h1D, 5'h18), 0, 0, `SCC_EXC_ILLEGAL);
    issue(xf(`SCC_XO_MFSPR, 5'h04, 5'h18, 5'h1D), 0, 0, 0);
    chk("sprKept", gprWrData, 32'hC0DE0000);
    $display("test spr done");
  endtask
  task automatic t_sys;
    exc(sysWord, 0, 0, `SCC_EXC_SYSCALL);
    exc(rfiWord, 0, 0, `SCC_EXC_RFI);
    for (int i = 0; i < 4; i++) exc(xf(i[1] ? `SCC_XO_ECOWX : `SCC_XO_ECIWX, 5'h05, 5'h01, 5'h02), 32'h100,
        i[0] ? 32'h6 : 32'h8, i[0] ? `SCC_EXC_ALIGN : `SCC_EXC_NONE);
    $display("test system done");
  endtask
  task automatic t_cache;
    cache(`SCC_XO_ICBI, 1'b1, 1'b0, 1'b0, `SCC_BUS_ICBI, 3'h0);
    ackDelay <= 4'h3;
    cache(`SCC_XO_ICBI, 1'b0, 1'b0, 1'b0, `SCC_BUS_ICBI, 3'h0);
    ackDelay <= 4'h5;
    cache(`SCC_XO_DCBI, 1'b1, 1'b0, 1'b0, `SCC_BUS_KILL, 3'h0);
    cache(`SCC_XO_DCBI, 1'b1, 1'b0, 1'b1, `SCC_BUS_NONE, 3'h0);
    cache(`SCC_XO_ICBI, 1'b1, 1'b0, 1'b1, `SCC_BUS_NONE, 3'h0);
    cache(`SCC_XO_DCBI, 1'b1, 1'b1, 1'b0, `SCC_BUS_NONE, `SCC_EXC_PROT);
    $display("test cache done");
  endtask
  task automatic t_user;
    issue(xf(`SCC_XO_MTMSR, 5'h03, 5'h00, 5'h00), 0, 0, 32'h00004000);
    chk("userMode", machineStateReg, 32'h00004000);
    exc(rfiWord, 0, 0, `SCC_EXC_PRIV);
    exc(xf(`SCC_XO_MFMSR, 5'h07, 5'h00, 5'h00), 0, 0, `SCC_EXC_PRIV);
    exc(xf(`SCC_XO_MTSPR, 5'h01, 5'h18, 5'h1D), 0, 0, `SCC_EXC_PRIV);
    exc(xf(`SCC_XO_DCBI, 5'h00, 5'h02, 5'h03), 0, 0, `SCC_EXC_PRIV);
    exc(sysWord, 0, 0, `SCC_EXC_SYSCALL);
    cache(`SCC_XO_ICBI, 1'b1, 1'b0, 1'b0, `SCC_BUS_ICBI, 3'h0);
    $display("test user done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_msr();
    t_spr();
    t_sys();
    t_cache();
    t_user();
    print_verdict();
  end
endmodule // tb
`default_nettype wire
